// ===== common/dtr_pkg.sv
`default_nettype none

// ==========================================================================
// Shared constants of the temperature readout block
// ==========================================================================
package dtr_pkg;

    // ======================================================================
    // Register and command map
    // ======================================================================
    localparam logic [7:0] REG_LOCAL_MAIN = 8'h00;
    localparam logic [7:0] REG_REMOTE_MAIN = 8'h01;
    localparam logic [7:0] REG_STATUS = 8'h02;
    localparam logic [7:0] REG_CONFIG_RD = 8'h03;
    localparam logic [7:0] REG_CONFIG_WR = 8'h09;
    localparam logic [7:0] REG_REMOTE_FRAC = 8'h10;
    localparam logic [7:0] REG_LOCAL_FRAC = 8'h11;
    localparam logic [7:0] CMD_ONE_SHOT = 8'h0F;

    // ======================================================================
    // Fields and reset values
    // ======================================================================
    localparam int CFG_STANDBY_BIT = 6;
    localparam int STATUS_BUSY_BIT = 7;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] FAULT_CODE = 8'hFF;
    localparam int MEAS_W = 12;
    localparam int FRAC_W = 3;
    localparam logic [6:0] SLAVE_ADDR_DEF = 7'h2A;

    // ======================================================================
    // Timing: times in ms, counts derived from the 100 MHz clock
    // ======================================================================
    localparam int CLK_KHZ = 100000;
    localparam int TIMEOUT_MS = 25;
    localparam int INTEG_MS = 60;
    localparam int PERIOD_MS = 125;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
    localparam int INTEG_CYC = INTEG_MS * CLK_KHZ;
    localparam int PERIOD_CYC = PERIOD_MS * CLK_KHZ;

endpackage

`default_nettype wire

// ===== rtl/dtr_readout.sv
// Functional notes
// - Alarm active when a channel is above its high or below its low limit.
// - Alarm also active on a shorted or open remote diode.
// - Overheat output active while a temperature exceeds the overheat limit.
// - Each result is 11 bits, LSB one eighth degree.
// - Main registers at 00h and 01h; all-ones reports a remote diode fault.
// - Main reading unsigned whole degrees; below zero reads zero; 145 reads 91h.
// - Fraction bits readable: remote at 10h, local at 11h.
// - Each channel integrates for about 60 ms.
// - Every conversion measures both local and remote channels.
// - Standby bit zero converts freely; one-shot starts a full conversion.
// - Busy status bit high while a conversion runs.
// - Reads return previous completed results during a conversion.
// - Standby stops conversion timing; data kept; serial port still answers.
// - One-shot converts fully even in standby.
// - Standby write during conversion aborts it; old results stay.
// - Full conversion period is about 125 ms.
// - Access only by write, read, send and receive byte.
// - Receive byte returns the register picked by the last command byte.
// - Data bytes go out most significant bit first.
// - Main and fraction registers of both channels update together.
// - Fraction in upper three bits, lower five bits undefined.
// - Send byte with command 0Fh triggers a one-shot.
// - Standby select is configuration bit 6; one selects standby.
// - Serial logic resets when the clock stays low past 25 ms.
`default_nettype none

// ========================
// Two-channel temperature readout: sequencing, results, alarms, SMBus
// ========================
module dtr_readout #(
    parameter logic [6:0] SLAVE_ADDR = dtr_pkg::SLAVE_ADDR_DEF,
    parameter int TIMEOUT_CYC = dtr_pkg::TIMEOUT_CYC,
    parameter int INTEG_CYC = dtr_pkg::INTEG_CYC,
    parameter int PERIOD_CYC = dtr_pkg::PERIOD_CYC
) (
    input wire logic clock, // System clock, 100 MHz
    input wire logic rst_b, // Async reset, active low
    input wire logic scl, // SMBus clock pin
    input wire logic sda_in, // SMBus data pin level
    output logic sda_out, // SMBus data drive value
    output logic sda_oe, // SMBus data drive enable
    input wire logic signed [dtr_pkg::MEAS_W-1:0] local_meas, // Local die, eighths
    input wire logic signed [dtr_pkg::MEAS_W-1:0] remote_meas, // Remote diode, eighths
    input wire logic remote_diode_fault, // Diode short or open
    input wire logic [7:0] high_limit, // Alarm high limit
    input wire logic [7:0] low_limit, // Alarm low limit
    input wire logic [7:0] overheat_limit, // Overheat limit
    output logic alarm_out, // Alarm drive value
    output logic alarm_oe, // Alarm pulled low
    output logic overheat_out, // Overheat drive value
    output logic overheat_oe // Overheat pulled low
);
    import dtr_pkg::*;

    // ========================
    // Types and local constants
    // ========================
    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_LOCAL = 2'b01,
        CV_REMOTE = 2'b11,
        CV_WAIT = 2'b10
    } dtr_cv_state_t;

    // Rest of the period after both integrations, never below one cycle
    localparam int WAIT_CYC = (PERIOD_CYC > 2 * INTEG_CYC) ? PERIOD_CYC - 2 * INTEG_CYC : 1;
    localparam int TMR_MAX = (WAIT_CYC > INTEG_CYC) ? WAIT_CYC : INTEG_CYC;
    localparam int TMR_W = $clog2(TMR_MAX + 1);
    localparam int TEMP_W = 8 + FRAC_W;

    // ========================
    // Input synchronisers
    // ========================
    logic scl_m_r, scl_s_r, sda_m_r, sda_s_r;
    logic [MEAS_W-1:0] loc_m_r, loc_s_r, rem_m_r, rem_s_r;
    logic flt_m_r, flt_s_r;

    // Pins from outside the clock domain pass two flops before use
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            loc_m_r <= '0;
            loc_s_r <= '0;
            rem_m_r <= '0;
            rem_s_r <= '0;
            flt_m_r <= 1'b0;
            flt_s_r <= 1'b0;
        end
        else
        begin
            scl_m_r <= scl;
            scl_s_r <= scl_m_r;
            sda_m_r <= sda_in;
            sda_s_r <= sda_m_r;
            loc_m_r <= local_meas;
            loc_s_r <= loc_m_r;
            rem_m_r <= remote_meas;
            rem_s_r <= rem_m_r;
            flt_m_r <= remote_diode_fault;
            flt_s_r <= flt_m_r;
        end
    end

    // ========================
    // Serial interface
    // ========================
    logic cmd_stb, data_stb;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;

    dtr_smbus_slave #(
        .SLAVE_ADDR(SLAVE_ADDR),
        .TIMEOUT_CYC(TIMEOUT_CYC)
    ) u_smbus (
        .clock(clock),
        .rst_b(rst_b),
        .scl_s(scl_s_r),
        .sda_s(sda_s_r),
        .tx_byte(tx_byte),
        .sda_oe(sda_oe),
        .cmd_stb(cmd_stb),
        .data_stb(data_stb),
        .rx_byte(rx_byte)
    );

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;

    // ========================
    // Command pointer and configuration
    // ========================
    logic [7:0] ptr_r, ptr_nxt;
    logic [7:0] cfg_r, cfg_nxt;
    logic one_shot, stby_write, standby;

    // Command byte selects the register; a data byte writes only the configuration, at 09h
    always_comb
    begin
        ptr_nxt = ptr_r;
        cfg_nxt = cfg_r;
        if (cmd_stb)
        begin
            ptr_nxt = rx_byte;
        end
        if (data_stb && ptr_r == REG_CONFIG_WR)
        begin
            cfg_nxt = rx_byte;
        end
    end

    // Pointer and configuration registers
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ptr_r <= PTR_RESET;
            cfg_r <= CONFIG_RESET;
        end
        else
        begin
            ptr_r <= ptr_nxt;
            cfg_r <= cfg_nxt;
        end
    end

    // Send byte 0Fh starts a one-shot; a write setting standby is the abort event
    assign one_shot = cmd_stb & (rx_byte == CMD_ONE_SHOT);
    assign stby_write = data_stb & (ptr_r == REG_CONFIG_WR) & rx_byte[CFG_STANDBY_BIT];
    assign standby = cfg_r[CFG_STANDBY_BIT];

    // ========================
    // Conversion sequencer
    // ========================
    dtr_cv_state_t cv_r, cv_nxt;
    logic [TMR_W-1:0] tmr_r, tmr_nxt;
    logic [TEMP_W-1:0] loc_pend_r, loc_pend_nxt;
    logic [TEMP_W-1:0] loc_temp_r, loc_temp_nxt;
    logic [TEMP_W-1:0] rem_temp_r, rem_temp_nxt;
    logic rem_flt_r, rem_flt_nxt;
    logic busy;
    logic integ_end, wait_end;

    // Negative readings clamp to zero; keep whole degrees and three fraction bits
    function automatic logic [TEMP_W-1:0] dtr_fmt(input logic [MEAS_W-1:0] v);
        logic [TEMP_W-1:0] r;
        r = v[MEAS_W-1] ? '0 : v[TEMP_W-1:0];
        return r;
    endfunction

    assign integ_end = (tmr_r == TMR_W'(INTEG_CYC - 1));
    assign wait_end = (tmr_r == TMR_W'(WAIT_CYC - 1));
    assign busy = (cv_r == CV_LOCAL) | (cv_r == CV_REMOTE);

    // Sequencer next state; abort has top priority so nothing is latched
    always_comb
    begin
        cv_nxt = cv_r;
        tmr_nxt = tmr_r + 1'b1;
        loc_pend_nxt = loc_pend_r;
        loc_temp_nxt = loc_temp_r;
        rem_temp_nxt = rem_temp_r;
        rem_flt_nxt = rem_flt_r;
        if (stby_write && cv_r != CV_IDLE)
        begin
            cv_nxt = CV_IDLE;
            tmr_nxt = '0;
        end
        else
        begin
            unique case (cv_r)
                CV_IDLE:
                begin
                    // Timer held in standby; only a one-shot wakes it
                    tmr_nxt = '0;
                    if (!standby || one_shot)
                    begin
                        cv_nxt = CV_LOCAL;
                    end
                end
                CV_LOCAL:
                begin
                    if (integ_end)
                    begin
                        // Hold local result until remote finishes
                        loc_pend_nxt = dtr_fmt(loc_s_r);
                        cv_nxt = CV_REMOTE;
                        tmr_nxt = '0;
                    end
                end
                CV_REMOTE:
                begin
                    if (integ_end)
                    begin
                        // Both channels committed in one edge
                        loc_temp_nxt = loc_pend_r;
                        rem_temp_nxt = dtr_fmt(rem_s_r);
                        rem_flt_nxt = flt_s_r;
                        cv_nxt = standby ? CV_IDLE : CV_WAIT;
                        tmr_nxt = '0;
                    end
                end
                CV_WAIT:
                begin
                    if (standby)
                    begin
                        cv_nxt = CV_IDLE;
                        tmr_nxt = '0;
                    end
                    else if (wait_end || one_shot)
                    begin
                        cv_nxt = CV_LOCAL;
                        tmr_nxt = '0;
                    end
                end
            endcase
        end
    end

    // Sequencer and result registers; results change only at commit
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cv_r <= CV_IDLE;
            tmr_r <= '0;
            loc_pend_r <= '0;
            loc_temp_r <= '0;
            rem_temp_r <= '0;
            rem_flt_r <= 1'b0;
        end
        else
        begin
            cv_r <= cv_nxt;
            tmr_r <= tmr_nxt;
            loc_pend_r <= loc_pend_nxt;
            loc_temp_r <= loc_temp_nxt;
            rem_temp_r <= rem_temp_nxt;
            rem_flt_r <= rem_flt_nxt;
        end
    end

    // ========================
    // Register read path
    // ========================
    logic [7:0] loc_main, rem_main, loc_frac, rem_frac, status;

    // Fault forces all-ones main and a zero fraction
    assign loc_main = loc_temp_r[TEMP_W-1:FRAC_W];
    assign rem_main = rem_flt_r ? FAULT_CODE : rem_temp_r[TEMP_W-1:FRAC_W];
    // Undefined low bits read as zero
    assign loc_frac = {loc_temp_r[FRAC_W-1:0], {(8 - FRAC_W){1'b0}}};
    assign rem_frac = rem_flt_r ? 8'h00 : {rem_temp_r[FRAC_W-1:0], {(8 - FRAC_W){1'b0}}};
    assign status = {busy, 7'h00};

    // Byte returned on a read follows the current pointer
    always_comb
    begin
        unique case (ptr_r)
            REG_LOCAL_MAIN: tx_byte = loc_main;
            REG_REMOTE_MAIN: tx_byte = rem_main;
            REG_REMOTE_FRAC: tx_byte = rem_frac;
            REG_LOCAL_FRAC: tx_byte = loc_frac;
            REG_STATUS: tx_byte = status;
            REG_CONFIG_RD: tx_byte = cfg_r;
            default: tx_byte = 8'h00;
        endcase
    end

    // ========================
    // Alarm outputs
    // ========================
    logic alarm_r, alarm_nxt, ovh_r, ovh_nxt;

    // Limits compare whole degrees of the last committed results
    always_comb
    begin
        alarm_nxt = (loc_main > high_limit) | (loc_main < low_limit)
            | (rem_main > high_limit) | (rem_main < low_limit)
            | rem_flt_r;
        ovh_nxt = (loc_main > overheat_limit) | (!rem_flt_r && rem_main > overheat_limit);
    end

    // Alarm registers
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            alarm_r <= 1'b0;
            ovh_r <= 1'b0;
        end
        else
        begin
            alarm_r <= alarm_nxt;
            ovh_r <= ovh_nxt;
        end
    end

    // Open-drain outputs: enable means pin pulled low (active)
    assign alarm_out = 1'b0;
    assign alarm_oe = alarm_r;
    assign overheat_out = 1'b0;
    assign overheat_oe = ovh_r;

endmodule

`default_nettype wire

// ===== rtl/dtr_smbus_slave.sv
`default_nettype none

// ========================
// SMBus byte engine: address match, ack, command/data bytes, one read byte
// ========================
module dtr_smbus_slave #(
    parameter logic [6:0] SLAVE_ADDR = dtr_pkg::SLAVE_ADDR_DEF,
    parameter int TIMEOUT_CYC = dtr_pkg::TIMEOUT_CYC
) (
    input wire logic clock, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic scl_s, // Synchronised serial clock
    input wire logic sda_s, // Synchronised serial data
    input wire logic [7:0] tx_byte, // Byte to return on a read
    output logic sda_oe, // Pull data line low
    output logic cmd_stb, // Command byte received
    output logic data_stb, // Data byte received
    output logic [7:0] rx_byte // Last received byte
);
    import dtr_pkg::*;

    typedef enum logic [2:0] {
        SB_IDLE = 3'b000,
        SB_ADDR = 3'b001,
        SB_ACK = 3'b011,
        SB_RX = 3'b010,
        SB_TX = 3'b110,
        SB_MACK = 3'b111
    } dtr_sb_state_t;

    localparam int TO_W = $clog2(TIMEOUT_CYC + 1);

    dtr_sb_state_t st_r, st_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic rd_r, rd_nxt;
    logic first_r, first_nxt;
    logic scl_d_r, sda_d_r;
    logic [TO_W-1:0] to_r, to_nxt;
    logic cmd_r, cmd_nxt, data_r, data_nxt;
    logic scl_rise, scl_fall, start_ev, stop_ev;

    // Edge and bus condition detection on the synchronised lines
    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // Next-state logic of the byte engine
    always_comb
    begin
        st_nxt = st_r;
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        rd_nxt = rd_r;
        first_nxt = first_r;
        cmd_nxt = 1'b0;
        data_nxt = 1'b0;
        // Counter saturates so a stuck-low clock keeps the engine idle
        to_nxt = scl_s ? '0 : ((to_r == TO_W'(TIMEOUT_CYC)) ? to_r : to_r + 1'b1);
        if (to_r == TO_W'(TIMEOUT_CYC))
        begin
            st_nxt = SB_IDLE;
        end
        else if (start_ev)
        begin
            st_nxt = SB_ADDR;
            cnt_nxt = '0;
            first_nxt = 1'b1;
        end
        else if (stop_ev)
        begin
            st_nxt = SB_IDLE;
        end
        else
        begin
            unique case (st_r)
                SB_IDLE: ;
                SB_ADDR, SB_RX:
                begin
                    if (scl_rise)
                    begin
                        shift_nxt = {shift_r[6:0], sda_s};
                        cnt_nxt = cnt_r + 1'b1;
                    end
                    else if (scl_fall && cnt_r == 4'h8)
                    begin
                        if (st_r == SB_ADDR)
                        begin
                            rd_nxt = shift_r[0];
                            st_nxt = (shift_r[7:1] == SLAVE_ADDR) ? SB_ACK : SB_IDLE;
                        end
                        else
                        begin
                            // First byte after a write address is the command
                            st_nxt = SB_ACK;
                            cmd_nxt = first_r;
                            data_nxt = ~first_r;
                            first_nxt = 1'b0;
                        end
                    end
                end
                SB_ACK:
                begin
                    if (scl_fall)
                    begin
                        cnt_nxt = '0;
                        st_nxt = rd_r ? SB_TX : SB_RX;
                        if (rd_r)
                        begin
                            shift_nxt = tx_byte;
                        end
                    end
                end
                SB_TX:
                begin
                    if (scl_fall)
                    begin
                        cnt_nxt = cnt_r + 1'b1;
                        shift_nxt = {shift_r[6:0], 1'b1};
                        if (cnt_r == 4'h7)
                        begin
                            st_nxt = SB_MACK;
                        end
                    end
                end
                SB_MACK:
                begin
                    // Only one byte per read; master ack or nack ends it
                    if (scl_rise)
                    begin
                        st_nxt = SB_IDLE;
                    end
                end
                default: st_nxt = SB_IDLE;
            endcase
        end
    end

    // Byte engine registers
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= SB_IDLE;
            shift_r <= 8'hFF;
            cnt_r <= '0;
            rd_r <= 1'b0;
            first_r <= 1'b0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            to_r <= '0;
            cmd_r <= 1'b0;
            data_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            rd_r <= rd_nxt;
            first_r <= first_nxt;
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            to_r <= to_nxt;
            cmd_r <= cmd_nxt;
            data_r <= data_nxt;
        end
    end

    // Drive low for ack, and for zero bits of the returned byte, MSB first
    assign sda_oe = (st_r == SB_ACK) | ((st_r == SB_TX) & ~shift_r[7]);
    assign cmd_stb = cmd_r;
    assign data_stb = data_r;
    assign rx_byte = shift_r;

endmodule

`default_nettype wire

// ===== tb/dtr_host.sv
`default_nettype none

// ==========================================
// Bit-banging SMBus host, 80 ns serial clock
// ==========================================
module dtr_host (
    input wire logic clock, // System clock
    input wire logic sda,   // Resolved data line
    output logic scl,       // Serial clock
    output logic sda_low    // Host pulls data low
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus: both lines released
    initial scl = 1'b1;
    initial sda_low = 1'b0;
    // Half a serial clock period
    task automatic half();
        repeat (4) @(negedge clock);
    endtask
    // Start or repeated start; data moves a clock after the low edge for hold
    task automatic start();
        @(negedge clock);
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
    endtask
    // Stop, entered with the clock low
    task automatic stop();
        @(negedge clock);
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask
    // Eight bits then the ack bit, most significant first
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--)
        begin
            @(negedge clock);
            sda_low = !d[i];
            repeat (3) @(negedge clock);
            scl = 1'b1;
            half();
            q[i] = sda;
            scl = 1'b0;
        end
    endtask
endmodule

`default_nettype wire

// ===== tb/dtr_readout_checker.sv
`default_nettype none

// ========================
// Port checks of readout
// ========================
module dtr_readout_checker #(
    parameter int TIMEOUT_CYC = 200
) (
    input wire logic clock, // Clock
    input wire logic rst_b, // Reset
    input wire logic scl, // Serial clock
    input wire logic sda_out, // Data value
    input wire logic sda_oe, // Data drive
    input wire logic [7:0] overheat_limit, // Limit
    input wire logic alarm_out, // Alarm value
    input wire logic overheat_out, // Overheat value
    input wire logic overheat_oe // Overheat drive
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    int low_r;
    int low_nxt;
    // Saturating length of clock low time
    always_comb low_nxt = scl ? 0 : (low_r > TIMEOUT_CYC + 9 ? low_r : low_r + 1);
    always_ff @(posedge clock or negedge rst_b)
        if (!rst_b)
            low_r <= 0;
        else
            low_r <= low_nxt;
    sequence s_ack;
        $rose(sda_oe);
    endsequence
    property p_sda_val; sda_out == 1'b0; endproperty
    a_sda_val: assert property (p_sda_val) else $error("sda value high");
    property p_alarm_val; alarm_out == 1'b0; endproperty
    a_alarm_val: assert property (p_alarm_val) else $error("alarm value high");
    property p_overheat_val; overheat_out == 1'b0; endproperty
    a_overheat_val: assert property (p_overheat_val) else $error("overheat value high");
    property p_reset_quiet; !$past(rst_b) |-> !sda_oe; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("sda driven at reset");
    property p_sda_edge; $changed(sda_oe) |-> !$past(scl, 3); endproperty
    a_sda_edge: assert property (p_sda_edge) else $error("sda moved in clock high");
    property p_ack_bound; s_ack |-> ##[1:300] !sda_oe; endproperty
    a_ack_bound: assert property (p_ack_bound) else $error("sda held too long");
    property p_timeout; low_r > TIMEOUT_CYC + 8 |-> !sda_oe; endproperty
    a_timeout: assert property (p_timeout) else $error("no release on timeout");
    property p_oh_max; overheat_limit == 8'hFF && $past(overheat_limit) == 8'hFF |-> !overheat_oe; endproperty
    a_oh_max: assert property (p_oh_max) else $error("overheat over full scale");
endmodule

bind dtr_readout dtr_readout_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_dtr_readout_checker (.clock(clock),
    .rst_b(rst_b), .scl(scl), .sda_out(sda_out), .sda_oe(sda_oe), .overheat_limit(overheat_limit),
    .alarm_out(alarm_out), .overheat_out(overheat_out), .overheat_oe(overheat_oe));

`default_nettype wire

// ===== tb/dtr_readout_tb.sv
`default_nettype none

// ======================
// Readout testbench
// ======================
module dtr_readout_tb;
    import dtr_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic fault = 1'b0;
    logic scl, sda_low, sda_oe, alarm_oe, overheat_oe;
    wire logic sda;
    logic signed [MEAS_W-1:0] lm = '0;
    logic signed [MEAS_W-1:0] rm = '0;
    logic [7:0] hl = 8'hFF;
    logic [7:0] ll = 8'h00;
    logic [7:0] ol = 8'hFF;
    logic [7:0] q, lmain, rmain;
    int bad_count = 0;
    int checks = 0;
    // Pull-up on the data line
    assign sda = !(sda_low | sda_oe);
    always #5 clock = ~clock;
    dtr_readout #(.TIMEOUT_CYC(200), .INTEG_CYC(400), .PERIOD_CYC(1000)) i_dtr_readout (.clock(clock),
        .rst_b(rst_b), .scl(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .local_meas(lm),
        .remote_meas(rm), .remote_diode_fault(fault), .high_limit(hl), .low_limit(ll),
        .overheat_limit(ol), .alarm_out(), .alarm_oe(alarm_oe), .overheat_out(), .overheat_oe(overheat_oe));
    dtr_host i_dtr_host (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One byte written by the host, ack expected
    task automatic put(input logic [7:0] d);
        logic [8:0] r;
        i_dtr_host.xfer({d, 1'b1}, r);
        chk({7'h0, r[0]}, 8'h00, "ack");
    endtask
    // Mode 0 send, 1 write, 2 read, 3 receive
    task automatic xact(input int mode, input logic [7:0] cmd, input logic [7:0] data);
        logic [8:0] r;
        i_dtr_host.start();
        if (mode != 3)
        begin
            put({SLAVE_ADDR_DEF, 1'b0});
            put(cmd);
            if (mode == 1)
                put(data);
            if (mode == 2)
                i_dtr_host.start();
        end
        if (mode >= 2)
        begin
            put({SLAVE_ADDR_DEF, 1'b1});
            i_dtr_host.xfer(9'h1FF, r);
            q = r[8:1];
        end
        i_dtr_host.stop();
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [7:0] exp, input string what);
        xact(2, cmd, 8'h00);
        chk(q, exp, what);
    endtask
    // Standby one-shots, abort, timeout
    initial
    begin
        void'($urandom(32'he1b69314));
        repeat (3) @(negedge clock);
        rst_b = 1'b1;
        repeat (3) @(negedge clock);
        xact(1, REG_CONFIG_WR, 8'h40);
        lmain = 8'h00;
        for (int i = 0; i < 4; i++)
        begin
            int n;
            lm = 12'(8 + $urandom % 1000);
            if (i == 2)
                lm = -lm;
            if (i == 3)
                lm = 12'(145 * 8 + $urandom % 8);
            rm = 12'(8 + $urandom % 1000);
            fault = (i == 0);
            hl = i == 1 ? 8'(lm >>> 3) - 8'h01 : 8'hFF;
            ll = i == 2 ? 8'(rm >>> 3) + 8'h01 : 8'h00;
            ol = i == 3 ? 8'(lm >>> 3) - 8'h01 : 8'hFF;
            xact(0, CMD_ONE_SHOT, 8'h00);
            rd(REG_LOCAL_MAIN, lmain, "previous local");
            rd(REG_STATUS, 8'h80, "busy");
            for (n = 0; n < 20 && q !== 8'h00; n++)
                xact(2, REG_STATUS, 8'h00);
            if (n == 20)
            begin
                bad_count++;
                summarize();
            end
            lmain = lm < 0 ? 8'h00 : 8'(lm >>> 3);
            rmain = fault ? FAULT_CODE : 8'(rm >>> 3);
            rd(REG_LOCAL_MAIN, lmain, "local main");
            rd(REG_REMOTE_MAIN, rmain, "remote main");
            xact(3, 8'h00, 8'h00);
            chk(q, rmain, "receive");
            rd(REG_REMOTE_FRAC, fault ? 8'h00 : {rm[2:0], 5'h00}, "remote frac");
            if (lm >= 0)
                rd(REG_LOCAL_FRAC, {lm[2:0], 5'h00}, "local frac");
            chk({7'h0, alarm_oe}, 8'(i != 3), "alarm");
            chk({7'h0, overheat_oe}, 8'(i == 3), "overheat");
            $display("one-shot test %0d done", i);
        end
        lm = 12'(8 + $urandom % 1000);
        xact(1, REG_CONFIG_WR, 8'h00);
        rd(REG_STATUS, 8'h80, "free run busy");
        xact(1, REG_CONFIG_WR, 8'h40);
        rd(REG_LOCAL_MAIN, lmain, "after abort");
        rd(REG_STATUS, 8'h00, "standby idle");
        $display("abort test done");
        i_dtr_host.start();
        put({SLAVE_ADDR_DEF, 1'b1});
        repeat (100) @(negedge clock);
        chk({7'h0, sda_oe}, 8'h01, "data driven");
        repeat (200) @(negedge clock);
        chk({7'h0, sda_oe}, 8'h00, "timeout release");
        i_dtr_host.stop();
        rd(REG_STATUS, 8'h00, "after timeout");
        $display("timeout test done");
        summarize();
    end
endmodule

`default_nettype wire
